// ==== rtl/fsp_pkg.sv ====
// Shared constants and types of the serial flash front end
package fsp_pkg;

   // Opcodes
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_STATUS_WR_EN = 8'h50;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_BYTE_PROG = 8'h02;
   localparam logic [7:0] OP_AUTO_INC_PROG = 8'hAD;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;

   // Status byte bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_WRITE_LATCH = 1;
   localparam int ST_LEVEL_LO = 2;
   localparam int ST_AUTO_INC = 6;
   localparam int ST_LOCK = 7;

   // Values after power-up
   localparam logic [3:0] PROTECT_LEVEL_RESET = 4'h7;
   localparam logic PROTECT_LOCK_RESET = 1'h0;

   // Array geometry and protection boundaries
   localparam int ADDR_W = 19;
   localparam logic [19:0] ARRAY_END = 20'h80000;
   localparam logic [19:0] BASE_EIGHTH = 20'h70000;
   localparam logic [19:0] BASE_QUARTER = 20'h60000;
   localparam logic [19:0] BASE_HALF = 20'h40000;
   localparam logic [18:0] MASK_BYTE = 19'h00000;
   localparam logic [18:0] MASK_WORD = 19'h00001;
   localparam logic [18:0] MASK_SECTOR = 19'h00FFF;
   localparam logic [18:0] MASK_BLOCK32 = 19'h07FFF;
   localparam logic [18:0] MASK_BLOCK64 = 19'h0FFFF;
   localparam logic [18:0] MASK_ALL = 19'h7FFFF;

   // Bytes in a complete command, opcode included
   localparam logic [2:0] LEN_BARE = 3'h1;
   localparam logic [2:0] LEN_STATUS_WR = 3'h2;
   localparam logic [2:0] LEN_AUTO_NEXT = 3'h3;
   localparam logic [2:0] LEN_ADDR = 3'h4;
   localparam logic [2:0] LEN_PROG = 3'h5;
   localparam logic [2:0] LEN_AUTO_FIRST = 3'h6;
   localparam logic [2:0] LEN_MAX = 3'h7;

   // Link-side parser phases
   typedef enum logic [2:0] {
      PH_OPCODE = 3'b000,
      PH_ADDRESS = 3'b001,
      PH_DUMMY = 3'b010,
      PH_ARRAY_OUT = 3'b011,
      PH_STATUS_OUT = 3'b100,
      PH_DATA_IN = 3'b101,
      PH_IGNORE = 3'b110
   } fsp_phase_e;

   // Internal operation kinds handed to the array core
   typedef enum logic [2:0] {
      OPK_NONE = 3'b000,
      OPK_BYTE = 3'b001,
      OPK_WORD = 3'b010,
      OPK_SECTOR = 3'b011,
      OPK_BLOCK32 = 3'b100,
      OPK_BLOCK64 = 3'b101,
      OPK_CHIP = 3'b110
   } fsp_kind_e;

   // Command as gathered on the link clock
   typedef struct packed {
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [15:0] data;
      logic [2:0] nbytes;
      logic [2:0] bitcnt;
   } fsp_cmd_s;

   // Request to the array core
   typedef struct packed {
      fsp_kind_e kind;
      logic [18:0] addr;
      logic [15:0] data;
   } fsp_op_s;

endpackage : fsp_pkg

// ==== rtl/fsp_sync.sv ====
// Multi-bit level synchroniser, two or three stages
`timescale 1ns/1ps
`default_nettype none
module fsp_sync #(
   parameter int W = 1,
   parameter int STAGES = 3
) (
   // Clock
   input wire logic clk,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] q_d;
   logic [W-1:0] q_q;

   // With three stages a bit changes only once stages two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (STAGES == 3) begin
            q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
         end else begin
            q_d[i] = s2_q[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
   end

   assign q = q_q;
endmodule : fsp_sync
`default_nettype wire

// ==== rtl/fsp_front_end.sv ====
// Serial flash front end: link parser, pause, status and protection
// Functional notes
// RULE_01: Input sampled on rising clock edges; output changes after falling edges.
// RULE_02: Both clock idle levels, low and high, are accepted.
// RULE_03: Pause enters or leaves with the clock low, only entered while selected.
// RULE_04: A pause pin change while clock high takes effect at next clock low.
// RULE_05: During pause output floats and input and clock are ignored.
// RULE_06: Deselect in pause resets interface; pause lasts while pause pin low.
// RULE_07: Status write refused when protect pin low and lock bit set.
// RULE_08: Busy flag is one during internal operation, zero once ready.
// RULE_09: While busy only status reads are honoured; 03H and 0BH array reads still run while busy.
// RULE_10: Program and erase refused while write latch is zero.
// RULE_11: Write latch cleared at reset and on completion of listed commands.
// RULE_12: Status bit six shows auto-increment mode; byte mode after reset.
// RULE_13: Protect levels guard nothing, top eighth, quarter, half or all.
// RULE_14: Whole-array erase only when every protect level bit is zero.
// RULE_15: After reset levels two..zero are one, other status bits zero.
// RULE_16: Host issues write enable before every program, erase or status write.
// RULE_17: Commands start at select fall, bytes shifted in MSB first.
// RULE_18: Deselect before a byte completes aborts the command.
// RULE_19: Reads use 03H with three address bytes or 0BH adding a dummy.
// RULE_20: Reads stream successive addresses until deselect, wrapping to zero.
// RULE_21: Pause freezes bit count, shift register and command state.
`timescale 1ns/1ps
`default_nettype none
module fsp_front_end (
   // System
   input wire logic sys_clk,
   input wire logic rst,
   // Serial link pins
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   output logic spi_so,
   output logic spi_so_oe_n,
   input wire logic hold_n,
   input wire logic wp_n,
   // Array core
   output logic [18:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   output logic op_req,
   output fsp_pkg::fsp_op_s op,
   input wire logic op_done,
   // Status view
   output logic [7:0] status
);
   // ---------------- Link clock domain ----------------
   fsp_pkg::fsp_cmd_s cmd_q, cmd_d;
   fsp_pkg::fsp_phase_e ph_q, ph_d;
   logic [7:0] sr_q, sr_d;
   logic [18:0] maddr_q, maddr_d;
   logic load_q, load_d;
   logic drv_q, drv_d;
   logic seen_q, seen_d;
   logic [7:0] osr_q, osr_d;
   logic so_q, so_d;
   logic [7:0] stat_l;
   logic frame_tgl_q, frame_tgl_d;

   fsp_sync #(.W(8), .STAGES(3)) u_stat_sync (
      .clk(spi_sck),
      .d(status),
      .q(stat_l)
   );

   always_comb begin
      logic [7:0] byte_in;
      logic [2:0] nb;
      byte_in = 8'h00;
      nb = 3'h0;
      cmd_d = cmd_q;
      ph_d = ph_q;
      sr_d = sr_q;
      maddr_d = maddr_q;
      load_d = load_q;
      drv_d = drv_q;
      seen_d = seen_q;
      // Edges while deselected or paused leave everything frozen
      if (!spi_cs_n && hold_n) begin // RULE_05 RULE_21
         if (frame_tgl_q == seen_q) begin
            ph_d = ph_q;
         end else begin
            // First edge after a select fall opens a new command
            ph_d = fsp_pkg::PH_OPCODE; // RULE_17 RULE_06
            cmd_d = '0;
            drv_d = 1'b0;
         end
         seen_d = frame_tgl_q;
         byte_in = {sr_q[6:0], spi_si}; // RULE_01
         sr_d = byte_in;
         load_d = 1'b0;
         cmd_d.bitcnt = cmd_d.bitcnt + 3'h1;
         if (cmd_d.bitcnt == 3'h0) begin
            nb = (cmd_d.nbytes == fsp_pkg::LEN_MAX) ? cmd_d.nbytes
                                                    : cmd_d.nbytes + 3'h1;
            cmd_d.nbytes = nb;
            unique case (ph_d)
               fsp_pkg::PH_OPCODE: begin
                  cmd_d.opcode = byte_in;
                  unique case (byte_in)
                     fsp_pkg::OP_STATUS_READ: begin
                        ph_d = fsp_pkg::PH_STATUS_OUT;
                        load_d = 1'b1;
                        drv_d = 1'b1;
                     end
                     fsp_pkg::OP_STATUS_WRITE: ph_d = fsp_pkg::PH_DATA_IN;
                     fsp_pkg::OP_AUTO_INC_PROG: begin
                        ph_d = stat_l[fsp_pkg::ST_AUTO_INC] ?
                               fsp_pkg::PH_DATA_IN : fsp_pkg::PH_ADDRESS;
                     end
                     fsp_pkg::OP_READ, fsp_pkg::OP_FAST_READ,
                     fsp_pkg::OP_BYTE_PROG, fsp_pkg::OP_SECTOR_ERASE,
                     fsp_pkg::OP_BLOCK32_ERASE, fsp_pkg::OP_BLOCK64_ERASE:
                        ph_d = fsp_pkg::PH_ADDRESS;
                     default: ph_d = fsp_pkg::PH_IGNORE;
                  endcase
               end
               fsp_pkg::PH_ADDRESS: begin
                  cmd_d.addr = {cmd_d.addr[15:0], byte_in};
                  if (nb == fsp_pkg::LEN_ADDR) begin
                     if (cmd_d.opcode == fsp_pkg::OP_READ) begin // RULE_19
                        ph_d = fsp_pkg::PH_ARRAY_OUT;
                        maddr_d = cmd_d.addr[18:0];
                        load_d = 1'b1;
                        drv_d = 1'b1;
                     end else if (cmd_d.opcode == fsp_pkg::OP_FAST_READ) begin
                        ph_d = fsp_pkg::PH_DUMMY; // RULE_19
                     end else if (cmd_d.opcode == fsp_pkg::OP_BYTE_PROG ||
                          cmd_d.opcode == fsp_pkg::OP_AUTO_INC_PROG) begin
                        ph_d = fsp_pkg::PH_DATA_IN;
                     end else begin
                        ph_d = fsp_pkg::PH_IGNORE;
                     end
                  end
               end
               fsp_pkg::PH_DUMMY: begin
                  ph_d = fsp_pkg::PH_ARRAY_OUT;
                  maddr_d = cmd_d.addr[18:0];
                  load_d = 1'b1;
                  drv_d = 1'b1;
               end
               fsp_pkg::PH_ARRAY_OUT: begin
                  maddr_d = maddr_q + 19'h00001; // RULE_20
                  load_d = 1'b1;
               end
               fsp_pkg::PH_STATUS_OUT: load_d = 1'b1;
               fsp_pkg::PH_DATA_IN: cmd_d.data = {cmd_d.data[7:0], byte_in};
               fsp_pkg::PH_IGNORE: ph_d = fsp_pkg::PH_IGNORE;
               default: ph_d = fsp_pkg::PH_IGNORE;
            endcase
         end
      end
   end

   always_ff @(posedge spi_sck) begin
      cmd_q <= cmd_d;
      ph_q <= ph_d;
      sr_q <= sr_d;
      maddr_q <= maddr_d;
      load_q <= load_d;
      drv_q <= drv_d;
      seen_q <= seen_d;
   end

   // Output shifter on the falling edge
   always_comb begin
      logic [7:0] src;
      src = (ph_q == fsp_pkg::PH_STATUS_OUT) ? stat_l : mem_rdata;
      osr_d = osr_q;
      so_d = so_q;
      if (!spi_cs_n && hold_n) begin // RULE_05 RULE_21
         if (load_q) begin
            so_d = src[7];
            osr_d = {src[6:0], 1'b0};
         end else begin
            so_d = osr_q[7];
            osr_d = {osr_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(negedge spi_sck) begin // RULE_01 RULE_02
      osr_q <= osr_d;
      so_q <= so_d;
   end

   assign spi_so = so_q;
   assign mem_addr = maddr_q;

   // ---------------- System clock domain ----------------
   logic [3:0] pin_l;
   logic sck_l, cs_l, hold_l, wp_l;
   logic drv_l;
   logic cs_prev_q, cs_prev_d;
   logic pause_q, pause_d;
   logic armed_q, armed_d;
   logic oe_n_q, oe_n_d;
   logic busy_q, busy_d;
   logic wel_q, wel_d;
   logic aai_q, aai_d;
   logic aai_end_q, aai_end_d;
   logic [18:0] aai_addr_q, aai_addr_d;
   logic [3:0] level_q, level_d;
   logic lock_q, lock_d;
   logic req_q, req_d;
   fsp_pkg::fsp_op_s op_q, op_d;

   fsp_sync #(.W(4), .STAGES(3)) u_pin_sync (
      .clk(sys_clk),
      .d({spi_sck, spi_cs_n, hold_n, wp_n}),
      .q(pin_l)
   );

   fsp_sync #(.W(1), .STAGES(3)) u_drv_sync (
      .clk(sys_clk),
      .d(drv_q),
      .q(drv_l)
   );

   assign {sck_l, cs_l, hold_l, wp_l} = pin_l;

   // Bytes that make a whole command for a given opcode
   function automatic logic [2:0] cmd_len(input logic [7:0] opc,
                                          input logic in_aai);
      logic [2:0] n;
      n = fsp_pkg::LEN_MAX;
      unique case (opc)
         fsp_pkg::OP_WRITE_ENABLE, fsp_pkg::OP_WRITE_DISABLE,
         fsp_pkg::OP_STATUS_WR_EN, fsp_pkg::OP_CHIP_ERASE_A,
         fsp_pkg::OP_CHIP_ERASE_B: n = fsp_pkg::LEN_BARE;
         fsp_pkg::OP_STATUS_WRITE: n = fsp_pkg::LEN_STATUS_WR;
         fsp_pkg::OP_BYTE_PROG: n = fsp_pkg::LEN_PROG;
         fsp_pkg::OP_SECTOR_ERASE, fsp_pkg::OP_BLOCK32_ERASE,
         fsp_pkg::OP_BLOCK64_ERASE: n = fsp_pkg::LEN_ADDR;
         fsp_pkg::OP_AUTO_INC_PROG:
            n = in_aai ? fsp_pkg::LEN_AUTO_NEXT : fsp_pkg::LEN_AUTO_FIRST;
         default: n = fsp_pkg::LEN_MAX;
      endcase
      return n;
   endfunction : cmd_len

   // Lowest protected address for a protect level
   function automatic logic [19:0] prot_base(input logic [3:0] lvl);
      logic [19:0] b;
      b = fsp_pkg::ARRAY_END;
      if (lvl[2]) begin // RULE_13
         b = 20'h00000;
      end else if (lvl[1:0] == 2'b11) begin
         b = fsp_pkg::BASE_HALF;
      end else if (lvl[1:0] == 2'b10) begin
         b = fsp_pkg::BASE_QUARTER;
      end else if (lvl[1:0] == 2'b01) begin
         b = fsp_pkg::BASE_EIGHTH;
      end
      return b;
   endfunction : prot_base

   always_comb begin
      logic cs_rise;
      logic whole;
      logic [19:0] base;
      logic [18:0] tgt;
      logic [18:0] mask;
      fsp_pkg::fsp_kind_e kind;
      cs_rise = cs_l && !cs_prev_q;
      whole = (cmd_q.bitcnt == 3'h0) && // RULE_18
              (cmd_q.nbytes == cmd_len(cmd_q.opcode, aai_q));
      base = prot_base(level_q);
      tgt = cmd_q.addr[18:0];
      mask = fsp_pkg::MASK_BYTE;
      kind = fsp_pkg::OPK_NONE;
      cs_prev_d = cs_l;
      busy_d = busy_q;
      wel_d = wel_q;
      aai_d = aai_q;
      aai_end_d = aai_end_q;
      aai_addr_d = aai_addr_q;
      level_d = level_q;
      lock_d = lock_q;
      req_d = 1'b0;
      op_d = op_q;
      // Pause follows the pause pin only while the clock is low
      pause_d = pause_q;
      if (!sck_l) begin // RULE_03 RULE_04
         if (hold_l) begin
            pause_d = 1'b0;
         end else if (!cs_l || pause_q) begin
            pause_d = 1'b1; // RULE_06
         end
      end
      armed_d = armed_q;
      if (!cs_l && cs_prev_q) begin
         armed_d = 1'b0;
      end else if (!cs_l && !drv_l) begin
         armed_d = 1'b1;
      end
      oe_n_d = !(!cs_l && !pause_q && armed_q && drv_l); // RULE_05
      frame_tgl_d = cs_rise ? !frame_tgl_q : frame_tgl_q; // RULE_06
      unique case (cmd_q.opcode)
         fsp_pkg::OP_BYTE_PROG: kind = fsp_pkg::OPK_BYTE;
         fsp_pkg::OP_AUTO_INC_PROG: begin
            kind = fsp_pkg::OPK_WORD;
            mask = fsp_pkg::MASK_WORD;
            tgt = aai_q ? aai_addr_q + 19'h00002
                        : {cmd_q.addr[18:1], 1'b0};
         end
         fsp_pkg::OP_SECTOR_ERASE: begin
            kind = fsp_pkg::OPK_SECTOR;
            mask = fsp_pkg::MASK_SECTOR;
         end
         fsp_pkg::OP_BLOCK32_ERASE: begin
            kind = fsp_pkg::OPK_BLOCK32;
            mask = fsp_pkg::MASK_BLOCK32;
         end
         fsp_pkg::OP_BLOCK64_ERASE: begin
            kind = fsp_pkg::OPK_BLOCK64;
            mask = fsp_pkg::MASK_BLOCK64;
         end
         fsp_pkg::OP_CHIP_ERASE_A, fsp_pkg::OP_CHIP_ERASE_B: begin
            kind = fsp_pkg::OPK_CHIP;
            mask = fsp_pkg::MASK_ALL;
            tgt = 19'h00000;
         end
         default: kind = fsp_pkg::OPK_NONE;
      endcase
      if (op_done && busy_q) begin
         busy_d = 1'b0; // RULE_08
         if (!aai_q || aai_end_q) begin
            wel_d = 1'b0; // RULE_11
            aai_d = 1'b0;
            aai_end_d = 1'b0;
         end
      end
      // Commands act when the select rises; busy blocks them, but status and array reads still run
      if (cs_rise && whole && !busy_q) begin // RULE_09
         if (cmd_q.opcode == fsp_pkg::OP_WRITE_ENABLE) begin
            wel_d = 1'b1;
         end else if (cmd_q.opcode == fsp_pkg::OP_WRITE_DISABLE) begin
            wel_d = 1'b0; // RULE_11
            aai_d = 1'b0; // RULE_12
            aai_end_d = 1'b0;
         end else if (cmd_q.opcode == fsp_pkg::OP_STATUS_WRITE) begin
            if (wel_q && !(!wp_l && lock_q)) begin // RULE_07
               lock_d = cmd_q.data[fsp_pkg::ST_LOCK];
               level_d = cmd_q.data[fsp_pkg::ST_AUTO_INC-1:
                                    fsp_pkg::ST_LEVEL_LO];
               wel_d = 1'b0; // RULE_11
            end
         end else if (kind != fsp_pkg::OPK_NONE && wel_q && // RULE_10
                      {1'b0, tgt | mask} < base && // RULE_13
                      (kind != fsp_pkg::OPK_CHIP ||
                       level_q == 4'h0)) begin // RULE_14
            busy_d = 1'b1; // RULE_08
            req_d = 1'b1;
            op_d.kind = kind;
            op_d.addr = tgt & ~mask;
            op_d.data = cmd_q.data;
            if (kind == fsp_pkg::OPK_WORD) begin
               aai_d = 1'b1; // RULE_12
               aai_addr_d = tgt;
               aai_end_d = ({1'b0, tgt} + 20'h00002) >= base; // RULE_11
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cs_prev_q <= 1'b1;
         pause_q <= 1'b0;
         armed_q <= 1'b0;
         oe_n_q <= 1'b1;
         frame_tgl_q <= 1'b0;
         busy_q <= 1'b0; // RULE_15
         wel_q <= 1'b0; // RULE_11
         aai_q <= 1'b0; // RULE_12
         aai_end_q <= 1'b0;
         aai_addr_q <= '0;
         level_q <= fsp_pkg::PROTECT_LEVEL_RESET; // RULE_15
         lock_q <= fsp_pkg::PROTECT_LOCK_RESET;
         req_q <= 1'b0;
         op_q <= '0;
      end else begin
         cs_prev_q <= cs_prev_d;
         pause_q <= pause_d;
         armed_q <= armed_d;
         oe_n_q <= oe_n_d;
         frame_tgl_q <= frame_tgl_d;
         busy_q <= busy_d;
         wel_q <= wel_d;
         aai_q <= aai_d;
         aai_end_q <= aai_end_d;
         aai_addr_q <= aai_addr_d;
         level_q <= level_d;
         lock_q <= lock_d;
         req_q <= req_d;
         op_q <= op_d;
      end
   end

   assign spi_so_oe_n = oe_n_q;
   assign op_req = req_q;
   assign op = op_q;
   assign status = {lock_q, aai_q, level_q, wel_q, busy_q};
endmodule : fsp_front_end
`default_nettype wire

// ==== tb/fsp_front_end_chk.sv ====
// Protocol checker for the flash front end
`timescale 1ns/1ps
`default_nettype none
module fsp_front_end_chk (
   // System
   input wire logic sys_clk,
   input wire logic rst,
   // Link
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe_n,
   input wire logic hold_n,
   input wire logic wp_n,
   // Core and status
   input wire logic [18:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   input wire logic op_req,
   input wire fsp_pkg::fsp_op_s op,
   input wire logic op_done,
   input wire logic [7:0] status
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_reset_value: assert property (disable iff (1'b0)
      rst |=> status == 8'h1C && !op_req && spi_so_oe_n)
      else $error("reset values wrong");
   a_busy_set: assert property (op_req |-> ##[0:1] status[0])
      else $error("busy not raised");
   a_busy_clear: assert property (op_done |-> ##[0:2] !status[0])
      else $error("busy not cleared");
   a_latch_clear: assert property (
      op_done && op.kind != fsp_pkg::OPK_WORD |-> ##[0:2] !status[1])
      else $error("write latch not cleared");
   a_req_latch: assert property (op_req |-> status[1])
      else $error("request without write latch");
   a_req_idle: assert property (op_req |-> !$past(status[0]))
      else $error("request while busy");
   a_chip_level: assert property (
      op_req && op.kind == fsp_pkg::OPK_CHIP |-> status[5:2] == 4'h0)
      else $error("whole erase while protected");
   a_lock_hold: assert property ((!wp_n && status[7]) [*6]
      |=> $stable({status[7], status[5:2]}))
      else $error("locked levels changed");
   a_oe_idle: assert property (spi_cs_n [*6] |-> spi_so_oe_n)
      else $error("output driven while deselected");
   a_oe_pause: assert property ((!hold_n && !spi_sck) [*7]
      |-> spi_so_oe_n)
      else $error("output driven while paused");
   c_prog: cover property (op_req && op.kind == fsp_pkg::OPK_BYTE);
   c_chip: cover property (op_req && op.kind == fsp_pkg::OPK_CHIP);
   c_pause: cover property (!hold_n && !spi_cs_n);
endmodule : fsp_front_end_chk
bind fsp_front_end fsp_front_end_chk i_chk (.sys_clk, .rst, .spi_sck,
   .spi_cs_n, .spi_si, .spi_so, .spi_so_oe_n, .hold_n, .wp_n, .mem_addr,
   .mem_rdata, .op_req, .op, .op_done, .status);
`default_nettype wire

// ==== tb/fsp_host_model.sv ====
// SPI host model driving the flash link
`timescale 1ns/1ps
`default_nettype none
module fsp_host_model (
   // Link pins
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si,
   output logic hold_n,
   input wire logic spi_so,
   input wire logic spi_so_oe_n
);
   logic mode3 = 1'b0;
   logic held_oe_n = 1'b0;
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
      hold_n = 1'b1;
   end
   task begin_frame(input logic m3);
      mode3 = m3;
      spi_sck = m3;
      #40;
      spi_cs_n = 1'b0;
      #64;
   endtask : begin_frame
   task end_frame;
      spi_sck = mode3;
      #16;
      spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      #160;
   endtask : end_frame
   // Released output reads back inverted so it can never match
   task xfer(input logic [7:0] tx, output logic [7:0] rx, input int nb,
         input int pause_at);
      rx = 8'h00;
      for (int i = 0; i < nb; i++) begin
         spi_sck = 1'b0;
         spi_si = tx[7 - i];
         #48;
         if (i == pause_at) begin
            hold_n = 1'b0;
            repeat (3) begin
               #32 spi_sck = 1'b1;
               spi_si = ~spi_si;
               #32 spi_sck = 1'b0;
            end
            #64;
            held_oe_n = spi_so_oe_n;
            spi_si = tx[7 - i];
            hold_n = 1'b1;
            #48;
         end
         spi_sck = 1'b1;
         rx = {rx[6:0], spi_so_oe_n ? ~spi_so : spi_so};
         #16;
      end
   endtask : xfer
endmodule : fsp_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the flash front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic sys_clk;
   logic rst;
   logic wp_n;
   logic op_done = 1'b0;
   wire logic spi_sck, spi_cs_n, spi_si, hold_n, spi_so, spi_so_oe_n;
   wire logic op_req;
   wire logic [18:0] mem_addr;
   wire logic [7:0] status;
   wire fsp_pkg::fsp_op_s op;
   wire logic [7:0] mem_rdata = mem_addr[7:0] ^ 8'h5A;
   int fail_count = 0;
   int tests_run = 0;
   int n_req = 0;
   int n0;
   int busy_cnt = 0;
   logic [7:0] rx;
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   fsp_front_end i_fsp_front_end (.sys_clk, .rst, .spi_sck, .spi_cs_n,
      .spi_si, .spi_so, .spi_so_oe_n, .hold_n, .wp_n, .mem_addr,
      .mem_rdata, .op_req, .op, .op_done, .status);
   fsp_host_model i_host (.spi_sck, .spi_cs_n, .spi_si, .hold_n, .spi_so,
      .spi_so_oe_n);
   // Array core stand-in: each operation stays busy for 400 cycles
   always @(negedge sys_clk) begin
      op_done <= busy_cnt == 1;
      if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
      if (op_req === 1'b1) begin
         busy_cnt <= 400;
         n_req <= n_req + 1;
      end
   end
   task chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task frame(input logic [47:0] v, input int n, input logic m3,
         input int p);
      i_host.begin_frame(m3);
      for (int k = 0; k < n; k++) begin
         i_host.xfer(v[47 - 8 * k -: 8], rx, 8, k == n - 1 ? p : 9);
      end
      i_host.end_frame();
   endtask : frame
   task write_enable_cmd;
      frame({8'h06, 40'h0}, 1, 1'b0, 9);
   endtask : write_enable_cmd
   task wait_idle;
      repeat (600) if (status[0] !== 1'b0) @(negedge sys_clk);
      repeat (4) @(negedge sys_clk);
   endtask : wait_idle
   task t_reset;
      chk("status", 8'h1C, status);
      frame({8'h05, 40'h0}, 2, 1'b0, 9);
      chk("status read mode 0", 8'h1C, rx);
      frame({8'h05, 40'h0}, 3, 1'b1, 9);
      chk("status read mode 3", 8'h1C, rx);
   endtask : t_reset
   task t_lock;
      write_enable_cmd();
      frame({16'h0180, 32'h0}, 2, 1'b0, 9);
      chk("lock set", 8'h80, status);
      @(negedge sys_clk) wp_n <= 1'b0;
      write_enable_cmd();
      frame({16'h0100, 32'h0}, 2, 1'b0, 9);
      chk("locked", 8'h80, status & 8'hFC);
      @(negedge sys_clk) wp_n <= 1'b1;
      write_enable_cmd();
      frame({16'h0104, 32'h0}, 2, 1'b0, 9);
      chk("level one", 8'h04, status);
   endtask : t_lock
   task t_prog;
      n0 = n_req;
      frame({40'h020001003C, 8'h0}, 5, 1'b0, 9);
      chk("no latch", n0, n_req);
      write_enable_cmd();
      frame({40'h0207FFFF3C, 8'h0}, 5, 1'b0, 9);
      chk("protected", n0, n_req);
      write_enable_cmd();
      frame({40'h020001003C, 8'h0}, 5, 1'b0, 9);
      chk("request", n0 + 1, n_req);
      chk("kind", fsp_pkg::OPK_BYTE, op.kind);
      chk("addr", 19'h00100, op.addr);
      chk("data", 8'h3C, op.data[7:0]);
      frame({8'h05, 40'h0}, 2, 1'b0, 9);
      chk("busy read", 8'h07, rx);
      write_enable_cmd();
      wait_idle();
      chk("after prog", 8'h04, status);
   endtask : t_prog
   task t_erase;
      n0 = n_req;
      write_enable_cmd();
      frame({8'h60, 40'h0}, 1, 1'b0, 9);
      chk("erase refused", n0, n_req);
      write_enable_cmd();
      frame({16'h0100, 32'h0}, 2, 1'b0, 9);
      write_enable_cmd();
      frame({8'hC7, 40'h0}, 1, 1'b0, 9);
      chk("erase kind", fsp_pkg::OPK_CHIP, op.kind);
      wait_idle();
      chk("after erase", 8'h00, status);
   endtask : t_erase
   task t_read;
      frame({40'h0307FFFF00, 8'h0}, 5, 1'b0, 9);
      chk("read top", 8'hA5, rx);
      frame({40'h0307FFFF00, 8'h0}, 6, 1'b0, 9);
      chk("read wrap", 8'h5A, rx);
      frame(48'h0B0000100000, 6, 1'b1, 9);
      chk("fast read", 8'h4A, rx);
   endtask : t_read
   task t_pause_abort;
      write_enable_cmd();
      frame({8'h05, 40'h0}, 2, 1'b0, 3);
      chk("paused oe", 1'b1, i_host.held_oe_n);
      chk("resumed", 8'h02, rx);
      frame({8'h04, 40'h0}, 1, 1'b0, 9);
      chk("latch off", 8'h00, status);
      n0 = n_req;
      i_host.begin_frame(1'b0);
      i_host.xfer(8'h06, rx, 4, 9);
      i_host.end_frame();
      frame({40'h0200020011, 8'h0}, 5, 1'b0, 9);
      chk("aborted", n0, n_req);
   endtask : t_pause_abort
   task results;
      $display("checks %0d errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      repeat (8) @(negedge sys_clk);
      t_reset();
      t_lock();
      t_prog();
      t_erase();
      t_read();
      t_pause_abort();
      results();
   end
   initial begin
      #300000;
      fail_count++;
      results();
   end
endmodule : testbench
`default_nettype wire
